// [core/opdec_pkg.sv]
// Package: encodings, field positions and decode result types for the operand field decoder
package opdec_pkg;

  // Segment register selections
  typedef enum logic [2:0] {
    SEG_EXTRA = 3'h0,
    SEG_CODE  = 3'h1,
    SEG_STACK = 3'h2,
    SEG_DATA  = 3'h3,
    SEG_ADD1  = 3'h4,
    SEG_ADD2  = 3'h5
  } seg_t;

  // Register operand width
  typedef enum logic [1:0] {
    RW_BYTE_LO = 2'h0,
    RW_BYTE_HI = 2'h1,
    RW_WORD    = 2'h2,
    RW_DWORD   = 2'h3
  } reg_width_t;

  // Displacement size
  typedef enum logic [1:0] {
    DISP_NONE = 2'h0,
    DISP_8    = 2'h1,
    DISP_16   = 2'h2,
    DISP_32   = 2'h3
  } disp_t;

  // Source of the register operand code
  typedef enum logic [1:0] {
    RSRC_OPCODE = 2'h0,
    RSRC_MIDDLE = 2'h1,
    RSRC_LOCATOR = 2'h2
  } reg_src_t;

  // Addressing byte field positions
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int MID_HI = 5;
  localparam int MID_LO = 3;
  localparam int LOC_HI = 2;
  localparam int LOC_LO = 0;

  // Scaled address byte field positions
  localparam int SC_HI = 7;
  localparam int SC_LO = 6;
  localparam int IX_HI = 5;
  localparam int IX_LO = 3;
  localparam int BS_HI = 2;
  localparam int BS_LO = 0;

  // Encodings
  localparam logic [1:0] CLASS_NODISP = 2'h0;
  localparam logic [1:0] CLASS_D8     = 2'h1;
  localparam logic [1:0] CLASS_DFULL  = 2'h2;
  localparam logic [1:0] CLASS_REG    = 2'h3;
  localparam logic [2:0] LOC_SCALED   = 3'h4;
  localparam logic [2:0] LOC_DIRECT16 = 3'h6;
  localparam logic [2:0] LOC_DIRECT32 = 3'h5;
  localparam logic [2:0] IDX_NONE     = 3'h4;
  localparam logic [2:0] REG_NONE     = 3'h0;
  localparam logic [2:0] REG_3        = 3'h3;
  localparam logic [2:0] REG_4        = 3'h4;
  localparam logic [2:0] REG_5        = 3'h5;
  localparam logic [2:0] REG_6        = 3'h6;
  localparam logic [2:0] REG_7        = 3'h7;

  // Register selection
  typedef struct packed {
    logic [2:0] num;
    reg_width_t width;
  } reg_sel_t;

  // Effective address form
  typedef struct packed {
    logic       is_reg;
    logic       sib_needed;
    logic       base_en;
    logic [2:0] base;
    logic       index_en;
    logic [2:0] index;
    logic [1:0] scale;
    disp_t      disp;
    logic       wide_addr;
    seg_t       seg;
  } ea_t;

endpackage : opdec_pkg

// [core/operand_field_decoder.sv]
// Operand field decoder: register, segment and effective-address selection
//
// Behaviour
// - Byte mode: codes 0-3 low, 4-7 high bytes
// - Full size: whole register, 16 or 32 bits
// - Two-bit segment field picks four segments
// - Three-bit field adds two segments; 110/111 unused
// - Implied-mode instructions expect no addressing bytes
// - Scaled byte only: 32-bit, locator 100, class not 11
// - Scaled form from class, scale, index, base
// - Middle bits route as extension and register
// - Address size selects 16 or 32-bit table
// - Component width follows address size
// - 16-bit class 00 locator address forms
// - Classes 01/10 add d8/d16; 110 is reg5
// - Class 11 selects register via size rules
// - Real and virtual modes force default 16-bit
// - Size prefixes invert default for one instruction
// - Register code from opcode, middle or locator
`timescale 1ns/1ns

module operand_field_decoder
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // Instruction fields
  input  wire logic                valid_i,
  input  wire logic [7:0]          addr_byte_i,
  input  wire logic [7:0]          scaled_byte_i,
  input  wire logic [2:0]          opcode_reg_i,
  input  wire opdec_pkg::reg_src_t reg_src_i,
  input  wire logic                full_size_flag_i,
  input  wire logic                implied_mode_i,
  input  wire logic [1:0]          seg_select_two_bit_i,
  input  wire logic [2:0]          seg_select_three_bit_i,
  // Mode and prefixes
  input  wire logic                segment_size_flag_i,
  input  wire logic                real_or_v86_i,
  input  wire logic                op_size_prefix_i,
  input  wire logic                addr_size_prefix_i,
  // Results
  output logic                     valid_o,
  output opdec_pkg::reg_sel_t      reg_sel_o,
  output opdec_pkg::reg_sel_t      rm_reg_sel_o,
  output logic [2:0]               ext_sel_o,
  output opdec_pkg::seg_t          seg2_o,
  output opdec_pkg::seg_t          seg3_o,
  output logic                     seg3_bad_o,
  output logic                     wide_data_o,
  output logic                     addr_byte_needed_o,
  output opdec_pkg::ea_t           ea_o
);

  // ==========================================================
  // Field extraction
  wire logic [1:0] addressing_class = addr_byte_i[opdec_pkg::MOD_HI:opdec_pkg::MOD_LO];
  wire logic [2:0] opcode_extension_bits = addr_byte_i[opdec_pkg::MID_HI:opdec_pkg::MID_LO];
  wire logic [2:0] operand_locator = addr_byte_i[opdec_pkg::LOC_HI:opdec_pkg::LOC_LO];
  wire logic [1:0] sc_scale = scaled_byte_i[opdec_pkg::SC_HI:opdec_pkg::SC_LO];
  wire logic [2:0] sc_index = scaled_byte_i[opdec_pkg::IX_HI:opdec_pkg::IX_LO];
  wire logic [2:0] sc_base  = scaled_byte_i[opdec_pkg::BS_HI:opdec_pkg::BS_LO];

  // ==========================================================
  // Effective sizes
  wire logic default_size = segment_size_flag_i & ~real_or_v86_i;
  wire logic wide_data = default_size ^ op_size_prefix_i;
  wire logic wide_addr = default_size ^ addr_size_prefix_i;

  // ==========================================================
  // Register selection
  function automatic opdec_pkg::reg_sel_t pick_reg(input logic [2:0] code,
                                                   input logic full, input logic wide);
    opdec_pkg::reg_sel_t r;
    r = '0;
    if (full)
    begin
      r.num   = code;
      r.width = wide ? opdec_pkg::RW_DWORD : opdec_pkg::RW_WORD;
    end
    else
    begin
      r.num   = {1'b0, code[1:0]};
      r.width = code[2] ? opdec_pkg::RW_BYTE_HI : opdec_pkg::RW_BYTE_LO;
    end
    return r;
  endfunction : pick_reg

  wire logic [2:0] reg_code = (reg_src_i == opdec_pkg::RSRC_OPCODE)  ? opcode_reg_i :
                              (reg_src_i == opdec_pkg::RSRC_MIDDLE)  ? opcode_extension_bits :
                              operand_locator;
  wire opdec_pkg::reg_sel_t reg_sel = pick_reg(reg_code, full_size_flag_i, wide_data);
  wire opdec_pkg::reg_sel_t rm_sel  = pick_reg(operand_locator, full_size_flag_i, wide_data);

  // ==========================================================
  // Segment selection
  wire opdec_pkg::seg_t seg2 = opdec_pkg::seg_t'({1'b0, seg_select_two_bit_i});
  wire logic            seg3_bad = seg_select_three_bit_i[2] & seg_select_three_bit_i[1];
  wire opdec_pkg::seg_t seg3 = seg3_bad ? opdec_pkg::SEG_DATA
                                        : opdec_pkg::seg_t'(seg_select_three_bit_i);

  // ==========================================================
  // Effective address decode
  wire logic is_reg_form = (addressing_class == opdec_pkg::CLASS_REG);
  wire logic sib_needed  = wide_addr & ~is_reg_form & ~implied_mode_i
                           & (operand_locator == opdec_pkg::LOC_SCALED);

  opdec_pkg::ea_t ea16;
  opdec_pkg::ea_t ea32;
  opdec_pkg::ea_t ea;

  always_comb
  begin
    ea16 = '0;
    ea16.wide_addr = 1'b0;
    ea16.seg       = opdec_pkg::SEG_DATA;
    ea16.disp      = (addressing_class == opdec_pkg::CLASS_D8)    ? opdec_pkg::DISP_8 :
                     (addressing_class == opdec_pkg::CLASS_DFULL) ? opdec_pkg::DISP_16 :
                     opdec_pkg::DISP_NONE;
    case (operand_locator)
      3'h0, 3'h1, 3'h2, 3'h3:
      begin
        ea16.base_en  = 1'b1;
        ea16.base     = operand_locator[1] ? opdec_pkg::REG_5 : opdec_pkg::REG_3;
        ea16.index_en = 1'b1;
        ea16.index    = operand_locator[0] ? opdec_pkg::REG_7 : opdec_pkg::REG_6;
        if (operand_locator[1])
          ea16.seg = opdec_pkg::SEG_STACK;
      end
      3'h4, 3'h5:
      begin
        ea16.base_en = 1'b1;
        ea16.base    = operand_locator[0] ? opdec_pkg::REG_7 : opdec_pkg::REG_6;
      end
      opdec_pkg::LOC_DIRECT16:
      begin
        if (addressing_class == opdec_pkg::CLASS_NODISP)
          ea16.disp = opdec_pkg::DISP_16;
        else
        begin
          ea16.base_en = 1'b1;
          ea16.base    = opdec_pkg::REG_5;
          ea16.seg     = opdec_pkg::SEG_STACK;
        end
      end
      default:
      begin
        ea16.base_en = 1'b1;
        ea16.base    = opdec_pkg::REG_3;
      end
    endcase
  end

  wire logic [2:0] base32 = sib_needed ? sc_base : operand_locator;
  wire logic       no_base32 = (addressing_class == opdec_pkg::CLASS_NODISP)
                               & (base32 == opdec_pkg::LOC_DIRECT32);

  always_comb
  begin
    ea32 = '0;
    ea32.wide_addr  = 1'b1;
    ea32.sib_needed = sib_needed;
    ea32.base_en    = ~no_base32;
    ea32.base       = base32;
    ea32.disp       = (addressing_class == opdec_pkg::CLASS_D8)    ? opdec_pkg::DISP_8 :
                      (addressing_class == opdec_pkg::CLASS_DFULL) ? opdec_pkg::DISP_32 :
                      no_base32 ? opdec_pkg::DISP_32 : opdec_pkg::DISP_NONE;
    ea32.seg        = (ea32.base_en & ((base32 == opdec_pkg::REG_4)
                       | (base32 == opdec_pkg::REG_5))) ? opdec_pkg::SEG_STACK
                                                        : opdec_pkg::SEG_DATA;
    if (sib_needed && sc_index != opdec_pkg::IDX_NONE)
    begin
      ea32.index_en = 1'b1;
      ea32.index    = sc_index;
      ea32.scale    = sc_scale;
    end
  end

  always_comb
  begin
    ea = wide_addr ? ea32 : ea16;
    if (is_reg_form || implied_mode_i)
    begin
      ea        = '0;
      ea.is_reg = is_reg_form & ~implied_mode_i;
      ea.wide_addr = wide_addr;
      ea.seg    = opdec_pkg::SEG_DATA;
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      valid_o            <= 1'b0;
      reg_sel_o          <= '0;
      rm_reg_sel_o       <= '0;
      ext_sel_o          <= 3'h0;
      seg2_o             <= opdec_pkg::SEG_EXTRA;
      seg3_o             <= opdec_pkg::SEG_EXTRA;
      seg3_bad_o         <= 1'b0;
      wide_data_o        <= 1'b0;
      addr_byte_needed_o <= 1'b0;
      ea_o               <= '0;
    end
    else if (ce_i)
    begin
      valid_o            <= valid_i;
      reg_sel_o          <= reg_sel;
      rm_reg_sel_o       <= rm_sel;
      ext_sel_o          <= opcode_extension_bits;
      seg2_o             <= seg2;
      seg3_o             <= seg3;
      seg3_bad_o         <= seg3_bad;
      wide_data_o        <= wide_data;
      addr_byte_needed_o <= ~implied_mode_i;
      ea_o               <= ea;
    end
  end

endmodule : operand_field_decoder

// [dv/fetch_queue_model.sv]
// Instruction queue model: random instruction fields, legal segment codes unless told
`timescale 1ns/1ns
// ====
// Field source
module fetch_queue_model
(
  input  wire logic          clk_i,
  input  wire logic          bad_en_i,
  output logic [7:0]         addr_byte_o,
  output logic [7:0]         scaled_byte_o,
  output logic [2:0]         opcode_reg_o,
  output opdec_pkg::reg_src_t reg_src_o,
  output logic [1:0]         seg2_o,
  output logic [2:0]         seg3_o,
  output logic [5:0]         flags_o,
  output logic [1:0]         ctl_o
);
  int          seed = 32'h673C;
  logic [31:0] r = 32'h0;
  logic [3:0]  q = 4'h0;
  always @(negedge clk_i)
  begin
    r <= $random(seed);
    q <= 4'($random(seed));
  end
  assign addr_byte_o   = r[7:0];
  assign scaled_byte_o = r[15:8];
  assign opcode_reg_o  = r[18:16];
  assign reg_src_o     = opdec_pkg::reg_src_t'(r[20:19]);
  assign seg2_o        = r[22:21];
  assign seg3_o        = (!bad_en_i && r[25:24] == 2'h3) ? {1'b0, r[24:23]} : r[25:23];
  assign flags_o       = r[31:26];
  assign ctl_o         = {q[3], q[2:0] != 3'h0};
endmodule : fetch_queue_model

// [dv/operand_field_decoder_assertions.sv]
// Checker: port-level assertions for the operand field decoder
`timescale 1ns/1ns
// ====
// Assertions
module operand_field_decoder_assertions
(
  input wire logic clk_i, rst_n_i, ce_i, valid_i, full_size_flag_i, implied_mode_i,
  input wire logic segment_size_flag_i, real_or_v86_i, op_size_prefix_i, addr_size_prefix_i,
  input wire logic [7:0] addr_byte_i,
  input wire logic [2:0] opcode_reg_i, seg_select_three_bit_i,
  input wire logic [1:0] seg_select_two_bit_i,
  input wire opdec_pkg::reg_src_t reg_src_i,
  input wire logic valid_o, seg3_bad_o, wide_data_o, addr_byte_needed_o,
  input wire logic [2:0] ext_sel_o,
  input wire opdec_pkg::reg_sel_t reg_sel_o,
  input wire opdec_pkg::seg_t seg2_o, seg3_o,
  input wire opdec_pkg::ea_t ea_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  valid_pass_a: assert property (ce_i |=> valid_o == $past(valid_i)) else $error("valid lost");
  hold_frozen_a: assert property (!ce_i |=> $stable(ea_o) && $stable(reg_sel_o))
    else $error("outputs moved without enable");
  seg_two_a: assert property (ce_i |=> seg2_o == {1'b0, $past(seg_select_two_bit_i)})
    else $error("two-bit segment wrong");
  seg_three_a: assert property (ce_i && seg_select_three_bit_i < 3'h6 |=>
    seg3_o == $past(seg_select_three_bit_i)) else $error("three-bit segment wrong");
  seg_bad_a: assert property (ce_i |=>
    seg3_bad_o == ($past(seg_select_three_bit_i) > 3'h5)) else $error("bad segment flag wrong");
  ext_route_a: assert property (ce_i |=> ext_sel_o == $past(addr_byte_i[5:3]))
    else $error("extension bits wrong");
  implied_a: assert property (ce_i |=> addr_byte_needed_o == !$past(implied_mode_i))
    else $error("addressing byte need wrong");
  real_size_a: assert property (ce_i && real_or_v86_i |=>
    wide_data_o == $past(op_size_prefix_i)) else $error("real mode operand size wrong");
  sib_short_a: assert property (ce_i && !(segment_size_flag_i && !real_or_v86_i) &&
    !addr_size_prefix_i |=> !ea_o.sib_needed) else $error("scaled byte under 16-bit");
  class_reg_a: assert property (ce_i && addr_byte_i[7:6] == 2'h3 && !implied_mode_i |->
    ##1 ea_o.is_reg && !ea_o.sib_needed) else $error("register form wrong");
  byte_sel_a: assert property (ce_i && !full_size_flag_i &&
    reg_src_i == opdec_pkg::RSRC_OPCODE |=> reg_sel_o.num == {1'b0, $past(opcode_reg_i[1:0])})
    else $error("byte select wrong");
endmodule : operand_field_decoder_assertions
bind operand_field_decoder operand_field_decoder_assertions chk (.clk_i, .rst_n_i, .ce_i,
  .valid_i, .full_size_flag_i, .implied_mode_i, .segment_size_flag_i, .real_or_v86_i,
  .op_size_prefix_i, .addr_size_prefix_i, .addr_byte_i, .opcode_reg_i, .seg_select_three_bit_i,
  .seg_select_two_bit_i, .reg_src_i, .valid_o, .seg3_bad_o, .wide_data_o, .addr_byte_needed_o,
  .ext_sel_o, .reg_sel_o, .seg2_o, .seg3_o, .ea_o);

// [dv/operand_field_decoder_tb_top.sv]
// Testbench: random instruction fields checked against a reference model
`timescale 1ns/1ns
// ====
// Bench
module operand_field_decoder_tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, bad_en = 1'b0, valid_o, seg3_bad_o, wd, need;
  logic [7:0] ab, sb;
  logic [2:0] opr, s3, ext;
  logic [1:0] s2, ctl;
  logic [5:0] fl;
  opdec_pkg::reg_src_t src;
  opdec_pkg::reg_sel_t rs, rm, e_rs, e_rm;
  opdec_pkg::seg_t seg2, seg3;
  opdec_pkg::ea_t ea;
  logic [15:0] e_misc, got_misc;
  opdec_pkg::ea_t e_ea;
  int failures = 0, n_checks = 0, cyc = 0;
  logic dsz, wa;
  assign dsz = fl[2] & ~fl[3];
  assign wa  = dsz ^ fl[5];
  assign got_misc = {3'h0, valid_o, ext, seg2, seg3, seg3_bad_o, wd, need};
  initial forever #10 clk_i = ~clk_i;
  fetch_queue_model fq (.clk_i(clk_i), .bad_en_i(bad_en), .addr_byte_o(ab), .scaled_byte_o(sb),
    .opcode_reg_o(opr), .reg_src_o(src), .seg2_o(s2), .seg3_o(s3), .flags_o(fl), .ctl_o(ctl));
  operand_field_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ctl[0]), .valid_i(ctl[1]),
    .addr_byte_i(ab), .scaled_byte_i(sb), .opcode_reg_i(opr), .reg_src_i(src),
    .full_size_flag_i(fl[0]), .implied_mode_i(fl[1]), .seg_select_two_bit_i(s2),
    .seg_select_three_bit_i(s3), .segment_size_flag_i(fl[2]), .real_or_v86_i(fl[3]),
    .op_size_prefix_i(fl[4]), .addr_size_prefix_i(fl[5]), .valid_o(valid_o), .reg_sel_o(rs),
    .rm_reg_sel_o(rm), .ext_sel_o(ext), .seg2_o(seg2), .seg3_o(seg3), .seg3_bad_o(seg3_bad_o),
    .wide_data_o(wd), .addr_byte_needed_o(need), .ea_o(ea));
  function automatic opdec_pkg::reg_sel_t sel(logic [2:0] c, logic f, logic w);
    return {f ? c : {1'b0, c[1:0]}, f ? {1'b1, w} : {1'b0, c[2]}};
  endfunction : sel
  function automatic opdec_pkg::ea_t ea_ref(logic [7:0] a, logic [7:0] b, logic w, logic im);
    opdec_pkg::ea_t e;
    logic [1:0]     c;
    logic [2:0]     l, bs;
    e            = '0;
    c            = a[7:6];
    l            = a[2:0];
    e.wide_addr  = w;
    e.seg        = opdec_pkg::SEG_DATA;
    e.sib_needed = w && l == 3'h4 && c != 2'h3 && !im;
    bs           = e.sib_needed ? b[2:0] : l;
    if (im || c == 2'h3)
      e.is_reg = !im;
    else if (w)
    begin
      e.base_en = !(c == 2'h0 && bs == 3'h5);
      e.base    = e.base_en ? bs : 3'h0;
      e.disp    = c == 2'h1 ? opdec_pkg::DISP_8
                : (c == 2'h2 || !e.base_en) ? opdec_pkg::DISP_32 : opdec_pkg::DISP_NONE;
      if (e.base_en && (bs == 3'h4 || bs == 3'h5))
        e.seg = opdec_pkg::SEG_STACK;
      if (e.sib_needed && b[5:3] != 3'h4)
        {e.index_en, e.index, e.scale} = {1'b1, b[5:3], b[7:6]};
    end
    else
    begin
      case (l)
        3'h0: {e.base, e.index} = {3'h3, 3'h6};
        3'h1: {e.base, e.index} = {3'h3, 3'h7};
        3'h2: {e.base, e.index} = {3'h5, 3'h6};
        3'h3: {e.base, e.index} = {3'h5, 3'h7};
        3'h4: e.base = 3'h6;
        3'h5: e.base = 3'h7;
        3'h6: e.base = 3'h5;
        default: e.base = 3'h3;
      endcase
      e.index_en = l < 3'h4;
      e.base_en  = !(c == 2'h0 && l == 3'h6);
      if (!e.base_en)
        e.base = 3'h0;
      e.disp = c == 2'h1 ? opdec_pkg::DISP_8
             : (c == 2'h2 || l == 3'h6) ? opdec_pkg::DISP_16 : opdec_pkg::DISP_NONE;
      if (l == 3'h2 || l == 3'h3 || (l == 3'h6 && e.base_en))
        e.seg = opdec_pkg::SEG_STACK;
    end
    return e;
  endfunction : ea_ref
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) {e_rs, e_rm, e_misc, e_ea} <= '0;
    else if (ctl[0])
    begin
      e_rs   <= sel(src == 0 ? opr : src == 1 ? ab[5:3] : ab[2:0], fl[0], dsz ^ fl[4]);
      e_rm   <= sel(ab[2:0], fl[0], dsz ^ fl[4]);
      e_ea   <= ea_ref(ab, sb, wa, fl[1]);
      e_misc <= {3'h0, ctl[1], ab[5:3], 1'b0, s2, s3 > 5 ? 3'h3 : s3, s3 > 5, dsz ^ fl[4], !fl[1]};
    end
  task automatic note(logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : note
  task automatic chk_sel(opdec_pkg::reg_sel_t g, opdec_pkg::reg_sel_t e);
    note(32'(g), 32'(e));
  endtask : chk_sel
  task automatic chk_ea(opdec_pkg::ea_t g, opdec_pkg::ea_t e);
    if (!g.base_en)
      g.base = 3'h0;
    note(32'(g), 32'(e));
  endtask : chk_ea
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 2000; i++)
    begin
      @(negedge clk_i);
      note(32'(got_misc), 32'(e_misc));
      chk_sel(rs, e_rs);
      chk_sel(rm, e_rm);
      chk_ea(ea, e_ea);
      bad_en  = i > 1000;
      rst_n_i = !(i inside {[1200:1202]});
    end
    tally_and_finish;
  end
endmodule : operand_field_decoder_tb_top
